//--- verilog/uhie_top.v
// usb host interrupt flag, force and enable registers behind axi4-lite
`timescale 1ns/10ps
`default_nettype none
`include "uhie_consts.vh"

module uhie_top
#(
    parameter ADDR_W = 12
)
(
    // clock and reset
    input  wire              I_CLOCK,
    input  wire              I_RSTN,
    // axi4-lite write address
    input  wire              I_AWVALID,
    output wire              O_AWREADY,
    input  wire [ADDR_W-1:0] I_AWADDR,
    input  wire [2:0]        I_AWPROT,
    // axi4-lite write data
    input  wire              I_WVALID,
    output wire              O_WREADY,
    input  wire [31:0]       I_WDATA,
    input  wire [3:0]        I_WSTRB,
    // axi4-lite write response
    output wire              O_BVALID,
    input  wire              I_BREADY,
    output wire [1:0]        O_BRESP,
    // axi4-lite read address
    input  wire              I_ARVALID,
    output wire              O_ARREADY,
    input  wire [ADDR_W-1:0] I_ARADDR,
    input  wire [2:0]        I_ARPROT,
    // axi4-lite read data
    output wire              O_RVALID,
    input  wire              I_RREADY,
    output wire [31:0]       O_RDATA,
    output wire [1:0]        O_RRESP,
    // interrupt sources, same clock, one-cycle pulses per bit
    input  wire [31:0]       I_SRC_SET,
    input  wire [31:0]       I_SRC_CLR,
    // interrupt state
    output wire              O_USB_IRQ,
    output wire [31:0]       O_IRQ_FLAGS,
    output wire [31:0]       O_IRQ_EN
);

    // write channel holding registers
    reg              aw_have_q;
    reg              aw_have_d;
    reg [ADDR_W-1:0] aw_addr_q;
    reg [ADDR_W-1:0] aw_addr_d;
    reg              w_have_q;
    reg              w_have_d;
    reg [31:0]       w_data_q;
    reg [31:0]       w_data_d;
    reg [3:0]        w_strb_q;
    reg [3:0]        w_strb_d;
    reg              bvalid_q;
    reg              bvalid_d;
    reg [1:0]        bresp_q;
    reg [1:0]        bresp_d;

    // read channel registers
    reg              rvalid_q;
    reg              rvalid_d;
    reg [31:0]       rdata_q;
    reg [31:0]       rdata_d;
    reg [1:0]        rresp_q;
    reg [1:0]        rresp_d;

    // interrupt state
    reg [31:0]       flags_q;
    reg [31:0]       enable_q;
    reg              irq_q;

    // write decode
    wire             wr_fire;
    wire [31:0]      lane_mask;
    wire [31:0]      wr_bits;
    wire             wr_mapped;
    wire [31:0]      force_bits;
    wire [31:0]      fclr_bits;
    wire [31:0]      eset_bits;
    wire [31:0]      eclr_bits;
    wire [31:0]      flags_d;
    wire [31:0]      enable_d;

    // read decode
    wire             rd_fire;
    reg [31:0]       rd_word;
    reg              rd_mapped;

    // handshake outputs; one write and one read outstanding at a time
    assign O_AWREADY = !aw_have_q && !bvalid_q;
    assign O_WREADY  = !w_have_q && !bvalid_q;
    assign O_ARREADY = !rvalid_q;
    assign O_BVALID  = bvalid_q;
    assign O_BRESP   = bresp_q;
    assign O_RVALID  = rvalid_q;
    assign O_RDATA   = rdata_q;
    assign O_RRESP   = rresp_q;
    assign O_IRQ_FLAGS = flags_q;
    assign O_IRQ_EN    = enable_q;
    assign O_USB_IRQ   = irq_q;

    // the write commits once both address and data are held
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // byte strobes widened to a bit mask; unstrobed lanes write nothing
    assign lane_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                        {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wr_bits = w_data_q & lane_mask & `UHIE_IMPL_MASK;

    assign wr_mapped = (aw_addr_q == `UHIE_OFF_FLAGS)
                    || (aw_addr_q == `UHIE_OFF_FLAG_CLR)
                    || (aw_addr_q == `UHIE_OFF_FORCE)
                    || (aw_addr_q == `UHIE_OFF_ENABLE)
                    || (aw_addr_q == `UHIE_OFF_EN_CLR)
                    || (aw_addr_q == `UHIE_OFF_EN_SET);

    // one-hot write strobes per register, zero unless a write commits
    // pipe positions of the force word are reserved, so a force never reaches pipe flags
    assign force_bits = (wr_fire && aw_addr_q == `UHIE_OFF_FORCE)
                      ? (wr_bits & `UHIE_FORCE_MASK) : `UHIE_ZERO32;
    assign fclr_bits  = (wr_fire && aw_addr_q == `UHIE_OFF_FLAG_CLR)
                      ? (wr_bits & `UHIE_SWCLR_MASK) : `UHIE_ZERO32;
    assign eset_bits  = (wr_fire && aw_addr_q == `UHIE_OFF_EN_SET)
                      ? wr_bits : `UHIE_ZERO32;
    assign eclr_bits  = (wr_fire && aw_addr_q == `UHIE_OFF_EN_CLR)
                      ? wr_bits : `UHIE_ZERO32;

    // per-bit flag and enable next state
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_bit
            if (((`UHIE_IMPL_MASK >> gi) & 32'h00000001) != 32'h00000000)
            begin : g_impl
                // set (source or force) beats any clear in the same cycle
                assign flags_d[gi] = I_SRC_SET[gi] || force_bits[gi]
                                  || (flags_q[gi] && !fclr_bits[gi]
                                      && !I_SRC_CLR[gi]);
                // set wins over clear when both are written
                assign enable_d[gi] = eset_bits[gi]
                                   || (enable_q[gi] && !eclr_bits[gi]);
            end
            else
            begin : g_rsvd
                // reserved position, constant zero
                assign flags_d[gi]  = 1'b0;
                assign enable_d[gi] = 1'b0;
            end
        end
    endgenerate

    // interrupt state registers; output is a registered and of flags and enables
    always @(posedge I_CLOCK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            flags_q  <= `UHIE_FLAGS_RST;
            enable_q <= `UHIE_ENABLE_RST;
            irq_q    <= 1'b0;
        end
        else
        begin
            flags_q  <= flags_d;
            enable_q <= enable_d;
            irq_q    <= |(flags_d & enable_d);
        end
    end

    // write channel next state
    always @*
    begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        // address and data are taken independently, in either order
        if (I_AWVALID && O_AWREADY)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = I_AWADDR;
        end
        if (I_WVALID && O_WREADY)
        begin
            w_have_d = 1'b1;
            w_data_d = I_WDATA;
            w_strb_d = I_WSTRB;
        end
        if (wr_fire)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_mapped ? `UHIE_RESP_OKAY : `UHIE_RESP_SLVERR;
        end
        else if (bvalid_q && I_BREADY)
        begin
            bvalid_d = 1'b0;
            bresp_d  = `UHIE_RESP_OKAY;
        end
    end

    // write channel registers
    always @(posedge I_CLOCK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_have_q  <= 1'b0;
            w_data_q  <= `UHIE_ZERO32;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `UHIE_RESP_OKAY;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    // read decode; write-only registers read as zero
    assign rd_fire = I_ARVALID && O_ARREADY;

    always @*
    begin
        rd_word   = `UHIE_ZERO32;
        rd_mapped = 1'b1;
        case (I_ARADDR)
            `UHIE_OFF_FLAGS:    rd_word = flags_q & `UHIE_IMPL_MASK;
            `UHIE_OFF_ENABLE:   rd_word = enable_q & `UHIE_IMPL_MASK;
            `UHIE_OFF_FLAG_CLR: rd_word = `UHIE_ZERO32;
            `UHIE_OFF_FORCE:    rd_word = `UHIE_ZERO32;
            `UHIE_OFF_EN_CLR:   rd_word = `UHIE_ZERO32;
            `UHIE_OFF_EN_SET:   rd_word = `UHIE_ZERO32;
            default:            rd_mapped = 1'b0;
        endcase
    end

    // read channel next state
    always @*
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rd_fire)
        begin
            rvalid_d = 1'b1;
            rdata_d  = rd_word;
            rresp_d  = rd_mapped ? `UHIE_RESP_OKAY : `UHIE_RESP_SLVERR;
        end
        else if (rvalid_q && I_RREADY)
        begin
            rvalid_d = 1'b0;
            rdata_d  = `UHIE_ZERO32;
            rresp_d  = `UHIE_RESP_OKAY;
        end
    end

    // read channel registers
    always @(posedge I_CLOCK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= `UHIE_ZERO32;
            rresp_q  <= `UHIE_RESP_OKAY;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

endmodule
`default_nettype wire

//--- verilog/uhie_consts.vh
// constants for the usb host interrupt set and enable block
//
// Overview of operation
// - a one written to the force register sets the matching dma or global host interrupt flag; pipe flags have no force bit
// - zero bits in a force write leave their flags unchanged
// - dma channel 1..6 enables, bits 25..30, set via enable-set, cleared via enable-clear
// - pipe 0..6 enables, bits 8..14, set via enable-set, cleared via enable-clear
// - wake-up enable, bit 6, set and cleared by writing one to set/clear bits
// - start-of-frame enable, bit 5, set and cleared by writing one
// - resume-received enable, bit 4, set and cleared by writing one
// - resume-sent enable, bit 3, set and cleared by writing one
// - bus-reset-sent enable, bit 2, set and cleared by writing one
// - detach enable, bit 1, set and cleared by writing one
// - attach enable, bit 0, set and cleared by writing one
// - usb interrupt output is high while any flag and its enable are both one
// - a one written to the flag-clear register clears that global flag (bits 6..0 only) unless a source sets it in the same cycle; zero does nothing
`ifndef UHIE_CONSTS_VH
`define UHIE_CONSTS_VH

// register byte offsets
`define UHIE_OFF_FLAGS      12'h404
`define UHIE_OFF_FLAG_CLR   12'h408
`define UHIE_OFF_FORCE      12'h40c
`define UHIE_OFF_ENABLE     12'h410
`define UHIE_OFF_EN_CLR     12'h414
`define UHIE_OFF_EN_SET     12'h418

// implemented bit positions: dma 30..25, pipes 14..8, globals 6..0
`define UHIE_IMPL_MASK      32'h7e007f7f
// flags that software may force: dma 30..25 and globals 6..0, pipes have no force bit
`define UHIE_FORCE_MASK     32'h7e00007f
// flags that software may clear directly (globals only)
`define UHIE_SWCLR_MASK     32'h0000007f

// reset values
`define UHIE_FLAGS_RST      32'h00000000
`define UHIE_ENABLE_RST     32'h00000000
`define UHIE_ZERO32         32'h00000000

// axi responses
`define UHIE_RESP_OKAY      2'b00
`define UHIE_RESP_SLVERR    2'b10

`endif

//--- verification/uhie_chk.sv
// port assertions for the usb host interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "uhie_consts.vh"
module uhie_chk
#(
    parameter ADDR_W = 12
)
(
    input wire logic              I_CLOCK,
    input wire logic              I_RSTN,
    input wire logic              I_AWVALID,
    input wire logic              O_AWREADY,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic              I_WVALID,
    input wire logic              O_WREADY,
    input wire logic [31:0]       I_WDATA,
    input wire logic [3:0]        I_WSTRB,
    input wire logic              O_BVALID,
    input wire logic              I_BREADY,
    input wire logic [1:0]        O_BRESP,
    input wire logic              O_RVALID,
    input wire logic              I_RREADY,
    input wire logic [31:0]       O_RDATA,
    input wire logic [31:0]       I_SRC_SET,
    input wire logic [31:0]       I_SRC_CLR,
    input wire logic              O_USB_IRQ,
    input wire logic [31:0]       O_IRQ_FLAGS,
    input wire logic [31:0]       O_IRQ_EN
);
    logic [ADDR_W-1:0] a_q;
    logic [31:0]       d_q;
    logic [3:0]        s_q;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);
    // capture the accepted write so its commit can be judged later
    always @(posedge I_CLOCK)
    begin
        if (I_AWVALID && O_AWREADY)
            a_q <= I_AWADDR;
        if (I_WVALID && O_WREADY)
        begin
            d_q <= I_WDATA;
            s_q <= I_WSTRB;
        end
    end
    // a full-word write commits at the edge where bvalid rises
    sequence s_wr(a);
        $rose(O_BVALID) && a_q == a && s_q == 4'hf && $past(I_SRC_SET) == 32'h0;
    endsequence
    sequence s_bwait;
        O_BVALID && !I_BREADY;
    endsequence
    AST_IRQ: assert property (O_USB_IRQ == |(O_IRQ_FLAGS & O_IRQ_EN))
        else $error("irq output disagrees with flags and enables");
    AST_RSVF: assert property ((O_IRQ_FLAGS & ~`UHIE_IMPL_MASK) == 32'h0)
        else $error("reserved flag bit set");
    AST_RSVE: assert property ((O_IRQ_EN & ~`UHIE_IMPL_MASK) == 32'h0)
        else $error("reserved enable bit set");
    AST_FORCE: assert property (s_wr(`UHIE_OFF_FORCE) |->
        (O_IRQ_FLAGS & d_q & `UHIE_FORCE_MASK) == (d_q & `UHIE_FORCE_MASK))
        else $error("forced flag not set");
    AST_FKEEP: assert property (s_wr(`UHIE_OFF_FORCE) ##0 $past(I_SRC_CLR) == 32'h0
        |-> (O_IRQ_FLAGS & ~(d_q & `UHIE_FORCE_MASK))
            == ($past(O_IRQ_FLAGS) & ~(d_q & `UHIE_FORCE_MASK)))
        else $error("force write disturbed a zero bit");
    AST_ESET: assert property (s_wr(`UHIE_OFF_EN_SET) |->
        (O_IRQ_EN & d_q & `UHIE_IMPL_MASK) == (d_q & `UHIE_IMPL_MASK))
        else $error("enable not set");
    AST_ECLR: assert property (s_wr(`UHIE_OFF_EN_CLR) |-> (O_IRQ_EN & d_q) == 32'h0)
        else $error("enable not cleared");
    AST_FCLR: assert property (s_wr(`UHIE_OFF_FLAG_CLR) |->
        (O_IRQ_FLAGS & d_q & `UHIE_SWCLR_MASK) == 32'h0)
        else $error("flag not cleared");
    AST_BHOLD: assert property (s_bwait |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    AST_RHOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
endmodule
bind uhie_top uhie_chk #(.ADDR_W(ADDR_W)) u_chk (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR), .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .O_RDATA(O_RDATA), .I_SRC_SET(I_SRC_SET), .I_SRC_CLR(I_SRC_CLR), .O_USB_IRQ(O_USB_IRQ),
    .O_IRQ_FLAGS(O_IRQ_FLAGS), .O_IRQ_EN(O_IRQ_EN));
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the usb host interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "uhie_consts.vh"
module testbench;
    logic        clk, rstn, awv, wv, bready, arv, rr;
    logic [11:0] awa, ara;
    logic [31:0] wd, ss, sc, ef, ee, v, u;
    wire         awr, wrd, bv, arr, rv, irq;
    wire  [1:0]  br, rresp;
    wire  [31:0] rdata, flg, en;
    int          checked, fail_count;
    logic [11:0] tbl [8] = '{12'h404, 12'h408, 12'h40c, 12'h410, 12'h414, 12'h418,
                             12'h41c, 12'h400};
    uhie_top #(.ADDR_W(12)) DUT (.I_CLOCK(clk), .I_RSTN(rstn), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_AWADDR(awa), .I_AWPROT(3'h0), .I_WVALID(wv), .O_WREADY(wrd),
        .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bready), .O_BRESP(br),
        .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .I_ARPROT(3'h0), .O_RVALID(rv),
        .I_RREADY(rr), .O_RDATA(rdata), .O_RRESP(rresp), .I_SRC_SET(ss), .I_SRC_CLR(sc),
        .O_USB_IRQ(irq), .O_IRQ_FLAGS(flg), .O_IRQ_EN(en));
    // clock at 100 mhz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // unmapped places answer slverr
    function automatic logic [1:0] resp(input logic [11:0] a);
        return (a < 12'h404 || a > 12'h418) ? `UHIE_RESP_SLVERR : `UHIE_RESP_OKAY;
    endfunction
    // write-only and unmapped places read zero
    function automatic logic [31:0] rexp(input logic [11:0] a);
        return (a == 12'h404) ? ef : (a == 12'h410) ? ee : 32'h0;
    endfunction
    function automatic void model(input logic [11:0] a, input logic [31:0] d);
        case (a)
            `UHIE_OFF_FORCE:    ef = ef | (d & `UHIE_FORCE_MASK);
            `UHIE_OFF_FLAG_CLR: ef = ef & ~(d & `UHIE_SWCLR_MASK);
            `UHIE_OFF_EN_SET:   ee = ee | (d & `UHIE_IMPL_MASK);
            `UHIE_OFF_EN_CLR:   ee = ee & ~d;
            default:            ;
        endcase
    endfunction
    task automatic state_chk;
        chk(flg, ef);
        chk(en, ee);
        chk({31'h0, irq}, {31'h0, |(ef & ee)});
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        bready <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge clk);
            if (!ad && awr)
            begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (!dd && wrd)
            begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (!bv);
        bready <= 1'b0;
        model(a, d);
        chk({30'h0, br}, {30'h0, resp(a)});
        state_chk();
    endtask
    task automatic rd(input logic [11:0] a);
        arv <= 1'b1;
        ara <= a;
        rr <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rr <= 1'b0;
        chk(rdata, rexp(a));
        chk({30'h0, rresp}, {30'h0, resp(a)});
    endtask
    task automatic close_out;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // cut a hang short well past the expected run
    initial
    begin
        #200000;
        fail_count++;
        close_out();
    end
    initial
    begin
        {awv, wv, bready, arv, rr, rstn} = 6'h0;
        {awa, ara, wd, ss, sc, ef, ee} = '0;
        void'($urandom(32'h14d3));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(12'h404);
        rd(12'h410);
        // every bit, reserved ones too: force, enable, disable, clear
        for (int b = 0; b < 32; b++)
        begin
            wr(`UHIE_OFF_FORCE, 32'h1 << b);
            wr(`UHIE_OFF_EN_SET, 32'h1 << b);
            wr(`UHIE_OFF_EN_CLR, 32'h1 << b);
            wr(`UHIE_OFF_FLAG_CLR, 32'hffffffff);
        end
        // source pulses, clear and set together on some bits
        for (int i = 0; i < 20; i++)
        begin
            v = $urandom;
            u = $urandom;
            ss <= v;
            sc <= u;
            @(posedge clk);
            ss <= 32'h0;
            sc <= 32'h0;
            ef = (ef & ~(u & `UHIE_IMPL_MASK)) | (v & `UHIE_IMPL_MASK);
            @(posedge clk);
            state_chk();
        end
        // random traffic over mapped, read-only and unmapped places
        for (int i = 0; i < 60; i++)
        begin
            logic [11:0] pa;
            v = $urandom;
            pa = tbl[$urandom_range(0, 7)];
            wr(pa, v);
            rd(pa);
        end
        close_out();
    end
endmodule
`default_nettype wire
